// ### bench/sbr_ctrl_properties.sv
/*
 checker for the command pins of sbr_ctrl
 sees only top ports; bound into sbr_ctrl after the module
*/
`timescale 1ns/1ps
module sbr_ctrl_props #(
	parameter int REFI_CYC = 200
) (
	// reset and link clock
	input wire logic        rstn,
	input wire logic        mem_clk,
	// command pins
	input wire logic        mem_cke,
	input wire logic        mem_odt,
	input wire logic        mem_cs_n,
	input wire logic        mem_ras_n,
	input wire logic        mem_cas_n,
	input wire logic        mem_we_n,
	input wire logic [1:0]  mem_ba,
	input wire logic [12:0] mem_a
);
	wire [3:0]   cmd      = {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n};
	wire         ap       = mem_a[sbr_pkg::AP_BIT];
	wire         is_act   = cmd == sbr_pkg::CMD_ACT;
	wire         is_ref   = cmd == sbr_pkg::CMD_REF;
	wire         is_pre   = cmd == sbr_pkg::CMD_PRE;
	wire         is_rw    = cmd == sbr_pkg::CMD_RD || cmd == sbr_pkg::CMD_WR;
	wire         sr_ent   = is_ref && !mem_cke;
	wire         idle     = mem_cs_n || cmd == sbr_pkg::CMD_NOP;
	wire [3:0]   bit_b    = 4'h1 << mem_ba;
	logic [3:0]  open_r;
	logic        ent_r;
	logic        owed_r;
	logic [15:0] gap_r;
	// auto-precharge counted as closing at once: looser than the device
	wire [3:0]   open_nxt = (is_ref || is_pre && ap) ? 4'h0 : is_act ? open_r | bit_b :
		(is_rw && ap || is_pre && !ap) ? open_r & ~bit_b : open_r;
	wire         ent_nxt  = sr_ent ? 1'b1 : mem_cke ? 1'b0 : ent_r;
	wire         owed_nxt = (mem_cke && ent_r) ? 1'b1 : (is_ref && mem_cke) ? 1'b0 : owed_r;
	wire [15:0]  gap_nxt  = (is_ref || !mem_cke) ? 16'h0 : gap_r + 16'h1;
	always_ff @(posedge mem_clk or negedge rstn) begin
		if (!rstn) begin
			open_r <= 4'h0;
			ent_r  <= 1'b0;
			owed_r <= 1'b0;
			gap_r  <= 16'h0;
		end else begin
			open_r <= open_nxt;
			ent_r  <= ent_nxt;
			owed_r <= owed_nxt;
			gap_r  <= gap_nxt;
		end
	end
	default clocking @(posedge mem_clk); endclocking
	default disable iff (!rstn);
	sequence s_exit;
		$rose(mem_cke) && ent_r;
	endsequence
	sequence s_quiet;
		!is_act && !is_ref;
	endsequence
	property p_rw_open;    is_rw |-> open_r[mem_ba]; endproperty
	property p_act_closed; is_act |-> !open_r[mem_ba]; endproperty
	property p_rc;         is_act |=> !(is_act && mem_ba == $past(mem_ba)); endproperty
	property p_odt_ent;    sr_ent |-> !mem_odt; endproperty
	property p_sr_hold;    sr_ent |=> !mem_cke [*2]; endproperty
	// exit edge and the two link cycles after it, three in all, the exit delay in link cycles
	property p_sr_exit;    s_exit |-> (idle && mem_cke) [*3]; endproperty
	property p_cke_keep;   s_exit |-> mem_cke [*6]; endproperty
	property p_odt_exit;   s_exit |-> !mem_odt [*6]; endproperty
	property p_ref_first;  sr_ent |-> !owed_r; endproperty
	property p_rfc;        is_ref && mem_cke |=> s_quiet [*2]; endproperty
	property p_refi;       gap_r <= 9 * REFI_CYC; endproperty
	a_rw_open:    assert property (p_rw_open) else $error("column command to closed bank");
	a_act_closed: assert property (p_act_closed) else $error("activate to open bank");
	a_rc:         assert property (p_rc) else $error("same bank activates too close");
	a_odt_ent:    assert property (p_odt_ent) else $error("termination on at entry");
	a_sr_hold:    assert property (p_sr_hold) else $error("clock enable left low early");
	a_sr_exit:    assert property (p_sr_exit) else $error("command inside exit delay");
	a_cke_keep:   assert property (p_cke_keep) else $error("clock enable dropped at exit");
	a_odt_exit:   assert property (p_odt_exit) else $error("termination on at exit");
	a_ref_first:  assert property (p_ref_first) else $error("re-entry with no refresh");
	a_rfc:        assert property (p_rfc) else $error("command inside refresh cycle");
	a_refi:       assert property (p_refi) else $error("refresh gap too long");
endmodule // sbr_ctrl_props

bind sbr_ctrl sbr_ctrl_props #(.REFI_CYC(REFI_CYC)) u_props (.rstn, .mem_clk, .mem_cke,
	.mem_odt, .mem_cs_n, .mem_ras_n, .mem_cas_n, .mem_we_n, .mem_ba, .mem_a);

// ### bench/sbr_mem_model.sv
/*
 behavioural memory device on the command pins
 assumes pins change after mem_clk rising edges; counts controller faults
*/
`timescale 1ns/1ps
module sbr_mem_model (
	// pins
	input  wire logic        mem_clk,
	input  wire logic        rstn,
	input  wire logic        cke,
	input  wire logic [3:0]  cmd,
	input  wire logic [1:0]  ba,
	input  wire logic [12:0] a,
	// observation
	output logic [7:0]       bad_cnt,
	output logic [7:0]       col_cnt,
	output logic [7:0]       ref_cnt,
	output logic [12:0]      last_acc,
	output logic             in_sr
);
	logic [3:0] open_r;
	logic       dll_on_r;
	wire        live = !in_sr && cke && !cmd[3];
	// no data path here, so latency is only the column command's own edge
	wire        rw   = live && cmd[2] && !cmd[1];
	always @(posedge mem_clk or negedge rstn) begin
		if (!rstn) begin
			{bad_cnt, col_cnt, ref_cnt, last_acc, in_sr, open_r} <= '0;
			dll_on_r <= 1'b1;
		end else begin
			if (!in_sr && !cke && cmd == sbr_pkg::CMD_REF) begin
				in_sr    <= 1'b1;
				dll_on_r <= 1'b0;
			end else if (in_sr && cke) begin
				in_sr    <= 1'b0;
				dll_on_r <= 1'b1;
			end
			if (live && cmd == sbr_pkg::CMD_ACT) begin
				bad_cnt    <= bad_cnt + {7'h0, open_r[ba]};
				open_r[ba] <= 1'b1;
			end
			if (rw) begin
				bad_cnt    <= bad_cnt + {7'h0, !open_r[ba]};
				col_cnt    <= col_cnt + 8'h1;
				last_acc   <= {!cmd[0], a[10], ba, a[8:0]};
				open_r[ba] <= open_r[ba] && !a[10];
			end
			if (live && cmd == sbr_pkg::CMD_PRE)
				open_r <= a[10] ? 4'h0 : open_r & ~(4'h1 << ba);
			if (live && cmd == sbr_pkg::CMD_REF) begin
				ref_cnt <= ref_cnt + 8'h1;
				open_r  <= 4'h0;
			end
		end
	end
endmodule // sbr_mem_model

// ### bench/test_sbr_ctrl.sv
/*
 testbench for sbr_ctrl with a memory model on its pins
 assumes the link clock comes from the controller's own divider
*/
`timescale 1ns/1ps
module test_sbr_ctrl;
	logic        clock, rstn, req_valid, req_write, req_ap, req_ready, sr_req, sr_active;
	logic [1:0]  req_bank;
	logic [12:0] req_row;
	logic [8:0]  req_col;
	logic        mem_clk, mem_cke, mem_odt, mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n, in_sr;
	logic [1:0]  mem_ba;
	logic [12:0] mem_a, last_acc;
	logic [7:0]  bad_cnt, col_cnt, ref_cnt, r;
	logic [31:0] rv;
	integer      seed;
	int          n_errors, n_tests, i;
	sbr_ctrl #(.REFI_CYC(200)) u_dut (.clock, .rstn, .req_valid, .req_write, .req_ap,
		.req_bank, .req_row, .req_col, .req_ready, .sr_req, .sr_active, .mem_clk, .mem_cke,
		.mem_odt, .mem_cs_n, .mem_ras_n, .mem_cas_n, .mem_we_n, .mem_ba, .mem_a);
	sbr_mem_model u_mem (.mem_clk, .rstn, .cke(mem_cke),
		.cmd({mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n}), .ba(mem_ba), .a(mem_a),
		.bad_cnt, .col_cnt, .ref_cnt, .last_acc, .in_sr);
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
		n_tests++;
		if (s !== e) begin
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
			n_errors++;
		end
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ready is combinational, so it is looked at on the falling edge
	task automatic acc(input logic w, ap, input logic [1:0] b, input logic [12:0] row,
		input logic [8:0] c);
		int n;
		logic [7:0] k;
		@(posedge clock);
		#1;
		k = col_cnt;
		n = 0;
		{req_valid, req_write, req_ap, req_bank, req_row, req_col} = {1'b1, w, ap, b, row, c};
		do begin
			@(negedge clock);
			n++;
		end while (req_ready !== 1'b1 && n < 400);
		@(posedge clock);
		#1 req_valid = 1'b0;
		while (col_cnt === k && n < 800) begin
			@(posedge clock);
			n++;
		end
		chk("column access", {3'h0, w, ap, b, c}, {3'h0, last_acc});
	endtask
	task automatic wait_sr(input logic v);
		for (int n = 0; n < 3000 && sr_active !== v; n++)
			@(posedge clock);
		#1;
	endtask
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	initial begin
		repeat (30000) @(posedge clock);
		n_errors++;
		wrap_up();
	end
	initial begin
		seed = 94442;
		{rstn, req_valid, req_write, req_ap, req_bank, req_row, req_col, sr_req} = '0;
		repeat (8) @(posedge clock);
		#1 rstn = 1'b1;
		acc(1'b1, 1'b1, 2'h3, 13'h1fff, 9'h1ff);
		acc(1'b0, 1'b0, 2'h3, 13'h0, 9'h0);
		acc(1'b1, 1'b0, 2'h3, 13'h0, 9'h0aa);
		acc(1'b0, 1'b1, 2'h0, 13'h1555, 9'h155);
		for (i = 0; i < 24; i++) begin
			rv = $random(seed);
			acc(rv[0], rv[1], rv[3:2], rv[16:4], rv[25:17]);
		end
		$display("test access done");
		r = ref_cnt;
		repeat (1200) @(posedge clock);
		chk("refresh while idle", 16'h1, {15'h0, (ref_cnt - r) >= 8'h2});
		$display("test refresh done");
		for (i = 0; i < 2; i++) begin
			#1 sr_req = 1'b1;
			wait_sr(1'b1);
			repeat (40) @(posedge clock);
			chk("in self refresh", 16'h1, {15'h0, in_sr});
			#1 sr_req = 1'b0;
			wait_sr(1'b0);
			repeat (8) @(posedge clock);
			chk("left self refresh", 16'h0, {15'h0, in_sr});
			r = ref_cnt;
			rv = $random(seed);
			acc(rv[0], rv[1], rv[3:2], rv[16:4], rv[25:17]);
		end
		#1 sr_req = 1'b1;
		wait_sr(1'b1);
		chk("refresh before re-entry", 16'h1, {15'h0, ref_cnt != r});
		#1 sr_req = 1'b0;
		wait_sr(1'b0);
		$display("test self refresh done");
		chk("bank order faults", 16'h0, {8'h0, bad_cnt});
		wrap_up();
	end
endmodule // test_sbr_ctrl

// ### core/sbr_ctrl.sv
/*
 memory controller that drives a ddr2-style sdram command port
 assumes a 50 MHz clock; the link clock is clock divided by two and driven out
*/
`timescale 1ns/1ps
// Function
// RULE_01: activate a bank's row before any read or write to it.
// RULE_02: device takes read or write the cycle after activate.
// RULE_03: additive latency 0..6; pick one meeting activate-to-column minimum.
// RULE_04: precharge a bank before re-activating it.
// RULE_05: same-bank activates apart by row cycle; any activates by rrd.
// RULE_06: read decodes bank and column; A10 picks auto-precharge.
// RULE_07: write decodes like read with write enable low.
// RULE_08: read auto-precharge starts al plus half burst later.
// RULE_09: write auto-precharge starts after burst plus write recovery.
// RULE_10: precharge with A10 high closes all banks.
// RULE_11: self refresh keeps data, ignores all but clock enable.
// RULE_12: dll switched off in self refresh, on at exit.
// RULE_13: termination off before self refresh entry.
// RULE_14: hold clock enable low while in self refresh.
// RULE_15: clock may stop after entry, running before exit.
// RULE_16: exit with nop, only nop until exit delay passes.
// RULE_17: keep clock enable high through the exit period.
// RULE_18: keep termination off during the exit period.
// RULE_19: one auto refresh after exit before re-entering self refresh.
// RULE_20: refresh row generated internally, address ignored.
// RULE_21: wait refresh cycle time before next activate or refresh.
// RULE_22: average refresh interval met, at most eight postponed.
// RULE_23: read latency al plus cl, write latency one less.
// RULE_24: chip select low, others high is no operation.
// RULE_25: chip select high ignores the other inputs.
// RULE_26: device samples pins on each rising edge.
// RULE_27: device tracks each bank idle or active.
module sbr_ctrl #(
	parameter int AL       = 2,
	parameter int REFI_CYC = sbr_pkg::REFI_CYC
) (
	// system
	input  wire logic        clock,
	input  wire logic        rstn,
	// user request
	input  wire logic        req_valid,
	input  wire logic        req_write,
	input  wire logic        req_ap,
	input  wire logic [1:0]  req_bank,
	input  wire logic [12:0] req_row,
	input  wire logic [8:0]  req_col,
	output logic             req_ready,
	// self refresh control
	input  wire logic        sr_req,
	output logic             sr_active,
	// memory pins
	output logic             mem_clk,
	output logic             mem_cke,
	output logic             mem_odt,
	output logic             mem_cs_n,
	output logic             mem_ras_n,
	output logic             mem_cas_n,
	output logic             mem_we_n,
	output logic [1:0]       mem_ba,
	output logic [12:0]      mem_a
);
	typedef enum logic [3:0] {
		ST_IDLE   = 4'h0,
		ST_ACT    = 4'h1,
		ST_COL    = 4'h3,
		ST_PRE    = 4'h2,
		ST_REF    = 4'h6,
		ST_SRE    = 4'h7,
		ST_SR     = 4'h5,
		ST_SRX    = 4'h4,
		ST_WAIT   = 4'hc
	} sbr_state_e;

	sbr_state_e  st_r, st_nxt;
	sbr_req_if   rq ();
	logic        div_r;
	logic        tgl_r, ack_s1_r, ack_s2_r, busy_r;
	logic        ack_tgl;
	logic [3:0]  cmd_pin;
	logic [3:0]  open_r;
	logic [sbr_pkg::CNT_W-1:0] wait_r, refi_r;
	logic [3:0]  owed_r;
	logic        need_ref_r, odt_r, sr_r;
	logic [sbr_pkg::CNT_W-1:0] rc_r [4];
	logic [sbr_pkg::CNT_W-1:0] rrd_r;

	// link cycles to system cycles
	function automatic logic [sbr_pkg::CNT_W-1:0] cyc(input int n);
		cyc = sbr_pkg::CNT_W'(n * sbr_pkg::LINK_DIV);
	endfunction

	wire issue   = rq.valid && rq.ready;
	wire wait_ok = (wait_r == '0);
	wire hit     = open_r[req_bank];
	wire act_ok  = (rc_r[req_bank] == '0) && (rrd_r == '0); // RULE_05
	wire ref_due = (owed_r != 4'h0);
	wire ref_must = (owed_r >= 4'(sbr_pkg::MAX_POSTPONE)); // RULE_22

	// divider makes the link clock; no second reference needed
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) div_r <= 1'b0;
		else       div_r <= ~div_r;
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ack_s1_r <= 1'b0;
			ack_s2_r <= 1'b0;
		end else begin
			ack_s1_r <= ack_tgl;
			ack_s2_r <= ack_s1_r;
		end
	end

	assign rq.ready = ~busy_r;

	// request toggle handshake to link domain; fields held while busy
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			tgl_r  <= 1'b0;
			busy_r <= 1'b0;
		end else if (issue) begin
			tgl_r  <= ~tgl_r;
			busy_r <= 1'b1;
		end else if (busy_r && (ack_s2_r == tgl_r)) begin
			busy_r <= 1'b0;
		end
	end

	logic [3:0]  q_cmd_r;
	logic [1:0]  q_bank_r;
	logic [12:0] q_addr_r;
	logic        q_cke_r;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			q_cmd_r  <= sbr_pkg::CMD_NOP;
			q_bank_r <= 2'h0;
			q_addr_r <= 13'h0000;
			q_cke_r  <= 1'b0;
		end else if (issue) begin
			q_cmd_r  <= rq.cmd;
			q_bank_r <= rq.bank;
			q_addr_r <= rq.addr;
			q_cke_r  <= rq.cke;
		end
	end

	// command selection per state
	always_comb begin
		st_nxt   = st_r;
		rq.valid = 1'b0;
		rq.cmd   = sbr_pkg::CMD_NOP;
		rq.bank  = req_bank;
		rq.addr  = 13'h0000;
		rq.cke   = 1'b1;
		unique case (st_r)
			ST_IDLE: begin
				if (wait_ok && !busy_r) begin
					if ((ref_due && !req_valid) || ref_must || (sr_req && need_ref_r)) begin
						rq.valid = 1'b1;
						rq.addr  = 13'h0400; // RULE_10
						st_nxt   = (open_r != 4'h0) ? ST_PRE : ST_REF;
						rq.cmd   = (open_r != 4'h0) ? sbr_pkg::CMD_PRE : sbr_pkg::CMD_REF;
					end else if (sr_req && open_r != 4'h0) begin
						rq.valid = 1'b1;
						rq.cmd   = sbr_pkg::CMD_PRE;
						rq.addr  = 13'h0400;
						st_nxt   = ST_PRE;
					end else if (sr_req && !odt_r) begin
						rq.valid = 1'b1;
						rq.cmd   = sbr_pkg::CMD_REF;
						rq.cke   = 1'b0; // RULE_13
						st_nxt   = ST_SRE;
					end else if (req_valid && hit) begin
						rq.valid = 1'b1; // RULE_01
						rq.cmd   = req_write ? sbr_pkg::CMD_WR : sbr_pkg::CMD_RD;
						rq.addr  = {2'h0, req_ap, 1'b0, req_col};
						st_nxt   = ST_COL;
					end else if (req_valid && open_r != 4'h0 && !hit) begin
						rq.valid = 1'b1; // RULE_04
						rq.cmd   = sbr_pkg::CMD_PRE;
						rq.addr  = 13'h0400;
						st_nxt   = ST_PRE;
					end else if (req_valid && act_ok) begin
						rq.valid = 1'b1;
						rq.cmd   = sbr_pkg::CMD_ACT;
						rq.addr  = req_row;
						st_nxt   = ST_ACT;
					end
				end
			end
			ST_ACT, ST_COL, ST_PRE, ST_REF:
				if (!busy_r) st_nxt = ST_IDLE;
			ST_SRE:
				if (!busy_r) st_nxt = ST_SR;
			ST_SR: begin
				rq.cke = 1'b0; // RULE_14
				if (!sr_req && wait_ok) begin
					rq.valid = 1'b1;
					rq.cke   = 1'b1; // RULE_15
					rq.cmd   = sbr_pkg::CMD_NOP; // RULE_16
					st_nxt   = ST_SRX;
				end
			end
			ST_SRX:
				if (!busy_r) st_nxt = ST_WAIT;
			ST_WAIT:
				if (wait_ok) st_nxt = ST_IDLE; // RULE_17
			default: st_nxt = ST_IDLE;
		endcase
	end

	assign req_ready = (st_r == ST_IDLE) && wait_ok && !busy_r && req_valid && hit
		&& !ref_must && !sr_req && !(ref_due && !req_valid);

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) st_r <= ST_IDLE;
		else       st_r <= st_nxt;
	end

	// bank tracking, timers
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			open_r     <= 4'h0;
			wait_r     <= '0;
			rrd_r      <= '0;
			need_ref_r <= 1'b0;
			sr_r       <= 1'b0;
			odt_r      <= 1'b0;
			for (int i = 0; i < 4; i++) rc_r[i] <= '0;
		end else begin
			if (wait_r != '0) wait_r <= wait_r - 1'b1;
			if (rrd_r  != '0) rrd_r  <= rrd_r - 1'b1;
			for (int i = 0; i < 4; i++)
				if (rc_r[i] != '0) rc_r[i] <= rc_r[i] - 1'b1;
			if (issue) begin
				unique case (rq.cmd)
					sbr_pkg::CMD_ACT: begin
						open_r[rq.bank] <= 1'b1;
						rc_r[rq.bank]   <= cyc(sbr_pkg::RC_CYC + 2); // RULE_05
						rrd_r           <= cyc(sbr_pkg::RRD_CYC + 2);
						wait_r          <= cyc(2); // RULE_02
					end
					sbr_pkg::CMD_RD, sbr_pkg::CMD_WR: begin
						if (rq.addr[sbr_pkg::AP_BIT]) open_r[rq.bank] <= 1'b0;
						// column spacing covers al plus burst and ap timing
						wait_r <= cyc(AL + sbr_pkg::RC_CYC); // RULE_03
					end
					sbr_pkg::CMD_PRE: begin
						open_r <= 4'h0;
						wait_r <= cyc(sbr_pkg::RP_CYC + 2);
					end
					sbr_pkg::CMD_REF: begin
						if (rq.cke) begin
							wait_r     <= cyc(sbr_pkg::RFC_CYC + 2); // RULE_21
							need_ref_r <= 1'b0; // RULE_19
						end else begin
							sr_r   <= 1'b1;
							wait_r <= cyc(2); // RULE_15
						end
					end
					sbr_pkg::CMD_NOP: if (st_r == ST_SR) begin
						sr_r       <= 1'b0;
						need_ref_r <= 1'b1;
						wait_r     <= cyc(sbr_pkg::XSNR_CYC + 2); // RULE_16
					end
					default: ;
				endcase
			end
		end
	end

	// refresh debt: one owed per interval, settled by each refresh
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			refi_r <= '0;
			owed_r <= 4'h0;
		end else begin
			logic tick, paid;
			tick = (refi_r == sbr_pkg::CNT_W'(REFI_CYC * sbr_pkg::LINK_DIV - 1));
			paid = issue && rq.cmd == sbr_pkg::CMD_REF;
			refi_r <= tick ? '0 : refi_r + 1'b1;
			if (sr_r) owed_r <= 4'h0; // device refreshes itself
			else if (tick && !paid && owed_r != 4'hf) owed_r <= owed_r + 1'b1; // RULE_22
			else if (paid && !tick && owed_r != 4'h0) owed_r <= owed_r - 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			sr_active <= 1'b0;
			mem_odt   <= 1'b0;
		end else begin
			sr_active <= sr_r;
			mem_odt   <= 1'b0; // RULE_18
		end
	end

	sbr_pin_drv u_drv (
		.link_clk (div_r),
		.rstn     (rstn),
		.req_tgl  (tgl_r),
		.req_cmd  (q_cmd_r),
		.req_bank (q_bank_r),
		.req_addr (q_addr_r),
		.req_cke  (q_cke_r),
		.ack_tgl  (ack_tgl),
		.cke_o    (mem_cke),
		.cmd_o    (cmd_pin),
		.ba_o     (mem_ba),
		.a_o      (mem_a)
	);

	assign mem_clk   = div_r;
	assign mem_cs_n  = cmd_pin[3];
	assign mem_ras_n = cmd_pin[2];
	assign mem_cas_n = cmd_pin[1];
	assign mem_we_n  = cmd_pin[0];
endmodule // sbr_ctrl

// ### core/sbr_pin_drv.sv
/*
 pin driver: registers one command per link clock and drives the command pins
 assumes link_clk is the divided clock the top produces; handshake toggles cross domains
*/
`timescale 1ns/1ps
module sbr_pin_drv (
	// link clock domain
	input  wire logic        link_clk,
	input  wire logic        rstn,
	// request from sequencer, system domain toggle handshake
	input  wire logic        req_tgl,
	input  wire logic [3:0]  req_cmd,
	input  wire logic [1:0]  req_bank,
	input  wire logic [12:0] req_addr,
	input  wire logic        req_cke,
	output logic             ack_tgl,
	// pins
	output logic             cke_o,
	output logic [3:0]       cmd_o,
	output logic [1:0]       ba_o,
	output logic [12:0]      a_o
);
	logic s1_r, s2_r, seen_r;
	wire  new_req = s2_r ^ seen_r;

	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
		end else begin
			s1_r <= req_tgl;
			s2_r <= s1_r;
		end
	end

	// one command per edge; nop fills idle edges so cke stays as last requested
	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) begin
			seen_r  <= 1'b0;
			ack_tgl <= 1'b0;
			cke_o   <= 1'b0;
			cmd_o   <= sbr_pkg::CMD_DESEL;
			ba_o    <= 2'h0;
			a_o     <= 13'h0000;
		end else if (new_req) begin
			seen_r  <= s2_r;
			ack_tgl <= s2_r;
			cke_o   <= req_cke;
			cmd_o   <= req_cmd;
			ba_o    <= req_bank;
			a_o     <= req_addr;
		end else begin
			cmd_o   <= sbr_pkg::CMD_NOP; // RULE_16
		end
	end
endmodule // sbr_pin_drv

// ### core/sbr_pkg.sv
/*
 package for the memory-side command controller: command encodings, timing counts
 assumes a 50 MHz system clock and a link clock derived by a divider in the controller
*/
package sbr_pkg;
	localparam int CLK_MHZ      = 50;
	// command encodings {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] CMD_DESEL = 4'hf;
	localparam logic [3:0] CMD_NOP   = 4'h7;
	localparam logic [3:0] CMD_ACT   = 4'h3;
	localparam logic [3:0] CMD_RD    = 4'h5;
	localparam logic [3:0] CMD_WR    = 4'h4;
	localparam logic [3:0] CMD_PRE   = 4'h2;
	localparam logic [3:0] CMD_REF   = 4'h1;
	// address bit that selects auto-precharge / precharge-all
	localparam int AP_BIT       = 10;
	// timing figures in ns, counts in link cycles (link = sys / 2)
	localparam int LINK_DIV     = 2;
	localparam int T_RC_NS      = 60;
	localparam int T_RRD_NS     = 10;
	localparam int T_RP_NS      = 15;
	localparam int T_RFC_NS     = 105;
	localparam int T_XSNR_NS    = 115;
	localparam int T_REFI_NS    = 7800;
	localparam int LINK_NS      = LINK_DIV * 1000 / CLK_MHZ;
	localparam int RC_CYC       = (T_RC_NS + LINK_NS - 1) / LINK_NS;
	localparam int RRD_CYC      = (T_RRD_NS + LINK_NS - 1) / LINK_NS;
	localparam int RP_CYC       = (T_RP_NS + LINK_NS - 1) / LINK_NS;
	localparam int RFC_CYC      = (T_RFC_NS + LINK_NS - 1) / LINK_NS;
	localparam int XSNR_CYC     = (T_XSNR_NS + LINK_NS - 1) / LINK_NS;
	localparam int REFI_CYC     = T_REFI_NS / LINK_NS;
	localparam int MAX_POSTPONE = 8;
	localparam int AL_MAX       = 6;
	localparam int CNT_W        = 16;
endpackage

// ### core/sbr_req_if.sv
/*
 request / answer carrier between the controller and its command sequencer
 assumes both ends run on the same clock
*/
`timescale 1ns/1ps
interface sbr_req_if;
	logic        valid;
	logic        ready;
	logic [3:0]  cmd;
	logic [1:0]  bank;
	logic [12:0] addr;
	logic        cke;
	modport src (output valid, output cmd, output bank, output addr, output cke, input ready);
	modport dst (input valid, input cmd, input bank, input addr, input cke, output ready);
endinterface
